//--- hdl/drp_base_fld.sv
// one six-bit base-address field register
module drp_base_fld (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // write port
    drp_wr_if.fld wr
);
    logic [5:0] fld_r;
    // only the field bits are held; everything else is dropped at decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fld_r <= drp_pkg::DRP_FLD_RST;
        end else if (wr.we) begin
            fld_r <= wr.wdata;
        end
    end
    assign wr.value = fld_r;
endmodule

//--- hdl/drp_pkg.sv
// package with register map, field layout and size codes for the data ram partition block
//==============================================================
// Contract
// - bits 31 to 16 of each base register read zero.
// - kernel program base holds writable six-bit field in bits 15 to 10.
// - bits 9 to 0 of base registers read zero; 1 KB steps.
// - reset clears every base register to zero.
// - user data base holds writable field in bits 15 to 10.
// - user program base holds writable field in bits 15 to 10.
// - ram size reads fixed byte count 4, 8, 16 or 32 KB.
// - ram size is read-only; writes have no effect.
package drp_pkg;
    //==============================================================
    // register byte offsets
    localparam logic [7:0] DRP_KPB_OFS = 8'h00;
    localparam logic [7:0] DRP_UDB_OFS = 8'h04;
    localparam logic [7:0] DRP_UPB_OFS = 8'h08;
    localparam logic [7:0] DRP_RSZ_OFS = 8'h0C;
    //==============================================================
    // base field layout
    localparam int DRP_FLD_LSB = 10;
    localparam int DRP_FLD_MSB = 15;
    localparam int DRP_FLD_W = 6;
    localparam logic [5:0] DRP_FLD_RST = 6'h00;
    //==============================================================
    // size codes in bytes
    localparam logic [31:0] DRP_SZ_4K = 32'h0000_1000;
    localparam logic [31:0] DRP_SZ_8K = 32'h0000_2000;
    localparam logic [31:0] DRP_SZ_16K = 32'h0000_4000;
    localparam logic [31:0] DRP_SZ_32K = 32'h0000_8000;
    localparam logic [31:0] DRP_ZERO = 32'h0000_0000;
    typedef enum logic [1:0] {DRP_RAM_4K, DRP_RAM_8K, DRP_RAM_16K, DRP_RAM_32K} drp_ram_t;
endpackage

//--- hdl/drp_regs.sv
// apb register block for data ram partition boundaries and ram size
module drp_regs #(
    parameter drp_pkg::drp_ram_t RAM_SIZE = drp_pkg::DRP_RAM_32K
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // partition boundaries in 1 KB units, ram size in bytes
    output logic [5:0] kernel_program_base,
    output logic [5:0] user_data_base,
    output logic [5:0] user_program_base,
    output logic [31:0] ram_size
);
    //==============================================================
    // decode
    drp_wr_if kpb_if ();
    drp_wr_if udb_if ();
    drp_wr_if upb_if ();
    logic [31:0] size_w;
    logic wr_acc;
    logic rd_acc;
    logic sel_kpb;
    logic sel_udb;
    logic sel_upb;
    logic sel_rsz;
    logic mapped;
    logic [5:0] wfld;
    logic [31:0] rd_nxt;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic pslverr_nxt;
    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    // only the word address matters; low two bits ignored
    assign sel_kpb = paddr[7:2] == drp_pkg::DRP_KPB_OFS[7:2];
    assign sel_udb = paddr[7:2] == drp_pkg::DRP_UDB_OFS[7:2];
    assign sel_upb = paddr[7:2] == drp_pkg::DRP_UPB_OFS[7:2];
    assign sel_rsz = paddr[7:2] == drp_pkg::DRP_RSZ_OFS[7:2];
    assign mapped = (paddr[31:8] == 24'h00_0000) & (sel_kpb | sel_udb | sel_upb | sel_rsz);
    assign wfld = pwdata[drp_pkg::DRP_FLD_MSB:drp_pkg::DRP_FLD_LSB];
    assign kpb_if.we = wr_acc & mapped & sel_kpb;
    assign udb_if.we = wr_acc & mapped & sel_udb;
    assign upb_if.we = wr_acc & mapped & sel_upb;
    assign kpb_if.wdata = wfld;
    assign udb_if.wdata = wfld;
    assign upb_if.wdata = wfld;
    //==============================================================
    // field storage
    drp_base_fld u_kpb (.pclk(pclk), .presetn(presetn), .wr(kpb_if.fld));
    drp_base_fld u_udb (.pclk(pclk), .presetn(presetn), .wr(udb_if.fld));
    drp_base_fld u_upb (.pclk(pclk), .presetn(presetn), .wr(upb_if.fld));
    assign kernel_program_base = kpb_if.value;
    assign user_data_base = udb_if.value;
    assign user_program_base = upb_if.value;
    //==============================================================
    // static ram size; no write path exists at all
    assign size_w = (RAM_SIZE == drp_pkg::DRP_RAM_4K) ? drp_pkg::DRP_SZ_4K :
                    (RAM_SIZE == drp_pkg::DRP_RAM_8K) ? drp_pkg::DRP_SZ_8K :
                    (RAM_SIZE == drp_pkg::DRP_RAM_16K) ? drp_pkg::DRP_SZ_16K :
                    drp_pkg::DRP_SZ_32K;
    assign ram_size = size_w;
    //==============================================================
    // read mux; base fields land at bits 15:10, rest zero
    assign rd_nxt = !mapped ? drp_pkg::DRP_ZERO :
        sel_kpb ? {16'h0000, kpb_if.value, 10'h000} :
        sel_udb ? {16'h0000, udb_if.value, 10'h000} :
        sel_upb ? {16'h0000, upb_if.value, 10'h000} :
        size_w;
    assign pslverr_nxt = psel & ~penable & ~mapped;
    // data registered in the setup cycle so prdata comes from a flop in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= drp_pkg::DRP_ZERO;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r <= (psel & ~penable & ~pwrite) ? rd_nxt : prdata_r;
            pslverr_r <= pslverr_nxt | (pslverr_r & psel & ~penable);
        end
    end
    assign prdata = rd_acc ? prdata_r : drp_pkg::DRP_ZERO;
    assign pslverr = psel & penable & pslverr_r;
    //==============================================================
    // checks
    base_rst_a: assert property (@(posedge pclk) $rose(presetn) |->
        kernel_program_base == 6'h00 && user_data_base == 6'h00 && user_program_base == 6'h00)
        else $error("base not zero after reset");
    kpb_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        kpb_if.we |=> kernel_program_base == $past(pwdata[15:10]))
        else $error("kernel program base not stored");
    udb_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        udb_if.we |=> user_data_base == $past(pwdata[15:10]))
        else $error("user data base not stored");
    upb_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        upb_if.we |=> user_program_base == $past(pwdata[15:10]))
        else $error("user program base not stored");
    rd_high_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_acc && !sel_rsz |-> prdata[31:16] == 16'h0000)
        else $error("upper base bits not zero");
    rd_low_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_acc && !sel_rsz |-> prdata[9:0] == 10'h000)
        else $error("low base bits not zero");
    size_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_acc && mapped && sel_rsz |-> prdata == size_w && $stable(ram_size))
        else $error("ram size read wrong");
    hold_base_a: assert property (@(posedge pclk) disable iff (!presetn)
        !kpb_if.we |=> $stable(kernel_program_base))
        else $error("kernel base changed without write");
endmodule

//--- hdl/drp_wr_if.sv
// interface carrying a decoded register write to a base field
interface drp_wr_if;
    logic we;
    logic [5:0] wdata;
    logic [5:0] value;
    modport ctl (output we, output wdata, input value);
    modport fld (input we, input wdata, output value);
endinterface

//--- verification/drp_regs_bench.sv
// self-checking apb bench for the data ram partition register block
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
//==============================================================
// bench top
module drp_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, ram_size, rd;
    logic [31:0] sz_seen [3];
    logic pready, pslverr, er;
    logic [5:0] kpb, udb, upb;
    int miscompares = 0;
    int check_count = 0;
    //==============================================================
    // clock and designs; extra instances only show the other size settings
    always #12.5 pclk = ~pclk;
    drp_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .kernel_program_base(kpb), .user_data_base(udb),
        .user_program_base(upb), .ram_size(ram_size));
    for (genvar k = 0; k < 3; k++) begin : g_sz
        drp_regs #(.RAM_SIZE(drp_pkg::drp_ram_t'(k))) i_sz (.pclk(pclk), .presetn(presetn),
            .psel(1'b0), .penable(1'b0), .pwrite(1'b0), .paddr(paddr), .pwdata(pwdata),
            .prdata(), .pready(), .pslverr(), .kernel_program_base(), .user_data_base(),
            .user_program_base(), .ram_size(sz_seen[k]));
    end
    //==============================================================
    // verdict, shared by the main sequence and the watchdog
    task automatic print_verdict;
        if (miscompares == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready, read data and error are all taken at one rising edge
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) begin
            miscompares++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic ee);
        xfer(1'b0, a, 32'h0000_0000);
        `CHK("prdata", e, rd)
        `CHK("pslverr", ee, er)
    endtask
    //==============================================================
    // main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) rd_chk(32'(i * 4), 32'h0000_0000, 1'b0);
        rd_chk(32'h0000_000C, 32'h0000_8000, 1'b0);
        `CHK("size 4k", 32'h0000_1000, sz_seen[0])
        `CHK("size 8k", 32'h0000_2000, sz_seen[1])
        `CHK("size 16k", 32'h0000_4000, sz_seen[2])
        // bases kept ordered and inside the ram size, as software must
        xfer(1'b1, 32'h0000_0000, 32'hFFFF_13FF);
        rd_chk(32'h0000_0000, 32'h0000_1000, 1'b0);
        xfer(1'b1, 32'h0000_0004, 32'h5A5A_2A5A);
        rd_chk(32'h0000_0004, 32'h0000_2800, 1'b0);
        xfer(1'b1, 32'h0000_0008, 32'h0000_5C00);
        rd_chk(32'h0000_0008, 32'h0000_5C00, 1'b0);
        `CHK("kernel_program_base", 6'h04, kpb)
        `CHK("user_data_base", 6'h0A, udb)
        `CHK("user_program_base", 6'h17, upb)
        xfer(1'b1, 32'h0000_000C, 32'h0000_0000);
        rd_chk(32'h0000_000C, 32'h0000_8000, 1'b0);
        `CHK("ram_size", 32'h0000_8000, ram_size)
        rd_chk(32'h0000_0010, 32'h0000_0000, 1'b1);
        xfer(1'b1, 32'h0000_0100, 32'h0000_0000);
        rd_chk(32'h0000_0000, 32'h0000_1000, 1'b0);
        // second reset in mid-run must clear the boundaries again
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) rd_chk(32'(i * 4), 32'h0000_0000, 1'b0);
        print_verdict();
    end
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #100us;
        miscompares++;
        print_verdict();
    end
endmodule
